// >>> core/tsp_entry_mem.sv
// Entry memory holding accepted bus cycles, registered read port
`timescale 1ns/1ps
module tsp_entry_mem
    import tsp_pkg::*;
(
    input wire logic clk_i,
    tsp_mem_if.mem m
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [ENT_W-1:0] store_q [DEPTH];  // No reset: contents gated by pointers

    // Write port
    always_ff @(posedge clk_i)
    begin
        if (m.wr_en)
        begin
            store_q[m.wr_addr] <= m.wr_data;
        end
    end

    // Read port, data valid the cycle after rd_en
    always_ff @(posedge clk_i)
    begin
        if (m.rd_en)
        begin
            m.rd_data <= store_q[m.rd_addr];
        end
    end
endmodule

// >>> core/tsp_mem_if.sv
// Carrier between the ingress control logic and its entry memory
`timescale 1ns/1ps
interface tsp_mem_if;
    import tsp_pkg::*;
    logic wr_en;                // Store one entry
    logic [AW-1:0] wr_addr;     // Store slot
    logic [ENT_W-1:0] wr_data;  // Entry stored
    logic rd_en;                // Fetch one entry
    logic [AW-1:0] rd_addr;     // Fetch slot
    logic [ENT_W-1:0] rd_data;  // Registered fetch result
    modport ctl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// >>> core/tsp_pkg.sv
// Constants and field layouts for the segmented transmit ingress block
package tsp_pkg;
    // ------------------------------------------------------------
    // Segment geometry
    // ------------------------------------------------------------
    localparam int SEG_N = 4;
    localparam int SEG_W = 128;
    localparam int EMPTY_W = 4;
    localparam int LINE_W = SEG_N * SEG_W;
    // Entry: {empty, bad, last, first, valid, data}
    localparam int ENT_W = LINE_W + SEG_N * (4 + EMPTY_W);
    localparam int POS_VALID = LINE_W;
    localparam int POS_FIRST = LINE_W + SEG_N;
    localparam int POS_LAST = LINE_W + 2 * SEG_N;
    localparam int POS_BAD = LINE_W + 3 * SEG_N;
    localparam int POS_EMPTY = LINE_W + 4 * SEG_N;
    // ------------------------------------------------------------
    // Elastic store sizing
    // ------------------------------------------------------------
    localparam int DEPTH = 16;
    localparam int AW = 4;
    localparam logic [AW:0] DEPTH_CNT = 5'h10;
    // Ready drops early enough to absorb four late cycles plus the ready flop
    localparam logic [AW:0] RDY_LIM = 5'h0B;
    // ------------------------------------------------------------
    // Register map (word offsets as byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_ISTAT = 8'h08;
    localparam logic [7:0] OFF_IMASK = 8'h0C;
    localparam int CTRL_FLUSH = 0;
    localparam int CTRL_EN = 1;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int EV_OVR = 0;
    localparam int EV_UNR = 1;
    localparam logic [1:0] IMASK_RST = 2'h0;
endpackage

// >>> core/tsp_tx_ingress.sv
// Transmit segmented bus ingress with back-pressure, overrun and underrun
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module tsp_tx_ingress
    import tsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Segmented local bus from user logic
    input wire logic [SEG_W-1:0] tx_seg0_word_i,
    input wire logic [SEG_W-1:0] tx_seg1_word_i,
    input wire logic [SEG_W-1:0] tx_seg2_word_i,
    input wire logic [SEG_W-1:0] tx_seg3_word_i,
    input wire logic tx_seg0_valid_i,
    input wire logic tx_seg1_valid_i,
    input wire logic tx_seg2_valid_i,
    input wire logic tx_seg3_valid_i,
    input wire logic tx_seg0_first_i,
    input wire logic tx_seg1_first_i,
    input wire logic tx_seg2_first_i,
    input wire logic tx_seg3_first_i,
    input wire logic tx_seg0_last_i,
    input wire logic tx_seg1_last_i,
    input wire logic tx_seg2_last_i,
    input wire logic tx_seg3_last_i,
    input wire logic tx_seg0_bad_packet_i,
    input wire logic tx_seg1_bad_packet_i,
    input wire logic tx_seg2_bad_packet_i,
    input wire logic tx_seg3_bad_packet_i,
    input wire logic [EMPTY_W-1:0] tx_seg0_empty_count_i,
    input wire logic [EMPTY_W-1:0] tx_seg1_empty_count_i,
    input wire logic [EMPTY_W-1:0] tx_seg2_empty_count_i,
    input wire logic [EMPTY_W-1:0] tx_seg3_empty_count_i,
    output logic tx_accept_ready_o,
    output logic tx_overrun_flag_o,
    output logic tx_underrun_flag_o,
    // Line side toward the MAC framer
    input wire logic drain_ready_i,
    output logic line_valid_o,
    output logic [LINE_W-1:0] line_word_o,
    output logic [SEG_N-1:0] line_lane_valid_o,
    output logic [SEG_N-1:0] line_first_o,
    output logic [SEG_N-1:0] line_last_o,
    output logic [SEG_N*EMPTY_W-1:0] line_empty_o,
    output logic line_error_o,
    output logic line_fcs_off_o,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // Segment gathering
    // ------------------------------------------------------------
    logic [SEG_W-1:0] seg_word [SEG_N];     // Per-lane data
    logic [SEG_N-1:0] seg_val;              // Per-lane enables
    logic [SEG_N-1:0] seg_first_raw;        // Unmasked first flags
    logic [SEG_N-1:0] seg_last_raw;         // Unmasked last flags
    logic [SEG_N-1:0] seg_bad_raw;          // Unmasked error flags
    logic [EMPTY_W-1:0] seg_empty_raw [SEG_N];
    logic [ENT_W-1:0] entry;                // Packed entry for the store
    logic [SEG_N-1:0] bad_last;             // Lanes closing a bad packet

    assign seg_word = '{tx_seg0_word_i, tx_seg1_word_i, tx_seg2_word_i, tx_seg3_word_i};
    assign seg_val = {tx_seg3_valid_i, tx_seg2_valid_i, tx_seg1_valid_i, tx_seg0_valid_i};
    assign seg_first_raw = {tx_seg3_first_i, tx_seg2_first_i, tx_seg1_first_i, tx_seg0_first_i};
    assign seg_last_raw = {tx_seg3_last_i, tx_seg2_last_i, tx_seg1_last_i, tx_seg0_last_i};
    assign seg_bad_raw = {tx_seg3_bad_packet_i, tx_seg2_bad_packet_i, tx_seg1_bad_packet_i, tx_seg0_bad_packet_i};
    assign seg_empty_raw = '{tx_seg0_empty_count_i, tx_seg1_empty_count_i,
                             tx_seg2_empty_count_i, tx_seg3_empty_count_i};

    // Lane 0 lands in the low bits: earliest bytes first on the line
    genvar g;
    generate
        for (g = 0; g < SEG_N; g++)
        begin : g_lane
            logic lane_last;
            logic lane_bad;
            assign lane_last = seg_val[g] & seg_last_raw[g];
            assign lane_bad = lane_last & seg_bad_raw[g];
            assign bad_last[g] = lane_bad;
            assign entry[g*SEG_W +: SEG_W] = seg_word[g];
            assign entry[POS_VALID + g] = seg_val[g];
            assign entry[POS_FIRST + g] = seg_val[g] & seg_first_raw[g];
            assign entry[POS_LAST + g] = lane_last;
            assign entry[POS_BAD + g] = lane_bad;
            // Empty only counts on a closing lane; low three bits forced on error
            assign entry[POS_EMPTY + g*EMPTY_W +: EMPTY_W] = !lane_last ? '0 :
                lane_bad ? {seg_empty_raw[g][3], 3'h0} : seg_empty_raw[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // Pointers and fill level
    // ------------------------------------------------------------
    tsp_mem_if mif ();
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] fill_q;
    logic [AW:0] fill_d;
    logic [DEPTH-1:0] badtag_q;     // Per-slot bad-packet marks, read with the pointer
    logic ctrl_en_q;                // Software gate on ready
    logic flush_q;                  // One-cycle transmit path reset pulse
    logic seg_any;
    logic store_full;
    logic store_empty;
    logic wr_go;
    logic rd_go;
    logic ovr_ev;
    logic unr_cond;

    assign seg_any = |seg_val;
    assign store_full = (fill_q == DEPTH_CNT);
    assign store_empty = (fill_q == '0);
    assign wr_go = seg_any && !store_full && !flush_q;
    assign rd_go = drain_ready_i && !store_empty && !flush_q;
    assign ovr_ev = seg_any && store_full && !flush_q;
    assign fill_d = fill_q + {4'h0, wr_go} - {4'h0, rd_go};

    assign mif.wr_en = wr_go;
    assign mif.wr_addr = wr_ptr_q;
    assign mif.wr_data = entry;
    assign mif.rd_en = rd_go;
    assign mif.rd_addr = rd_ptr_q;

    tsp_entry_mem u_mem (
        .clk_i(clk_i),
        .m(mif.mem)
    );

    // Pointer bookkeeping; flush empties the store
    always_ff @(posedge clk_i)
    begin
        if (rst_i || flush_q)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            fill_q <= '0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_q + AW'(wr_go);
            rd_ptr_q <= rd_ptr_q + AW'(rd_go);
            fill_q <= fill_d;
        end
    end

    // Bad-packet mark per slot
    always_ff @(posedge clk_i)
    begin
        if (wr_go)
        begin
            badtag_q[wr_ptr_q] <= |bad_last;
        end
    end

    // Ready computed from next fill so late pushes fit in the slack
    always_ff @(posedge clk_i)
    begin
        if (rst_i || flush_q)
        begin
            tx_accept_ready_o <= 1'b0;
        end
        else
        begin
            tx_accept_ready_o <= ctrl_en_q && (fill_d < RDY_LIM);
        end
    end

    // Overrun is sticky until the path is reset, so it cannot be missed
    always_ff @(posedge clk_i)
    begin
        if (rst_i || flush_q)
        begin
            tx_overrun_flag_o <= 1'b0;
        end
        else if (ovr_ev)
        begin
            tx_overrun_flag_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Line side
    // ------------------------------------------------------------
    logic in_pkt_q;                 // A packet is open on the line
    logic data_pend_q;              // Memory read data valid this cycle
    logic [SEG_N-1:0] rd_first;
    logic [SEG_N-1:0] rd_last;

    assign rd_first = mif.rd_data[POS_FIRST +: SEG_N];
    assign rd_last = mif.rd_data[POS_LAST +: SEG_N];
    // Dry while a packet is open; a word already fetched is not a gap
    assign unr_cond = drain_ready_i && store_empty && in_pkt_q && !data_pend_q && !flush_q;
    assign line_word_o = mif.rd_data[LINE_W-1:0];
    assign line_lane_valid_o = mif.rd_data[POS_VALID +: SEG_N];
    assign line_first_o = rd_first;
    assign line_last_o = rd_last;
    assign line_empty_o = mif.rd_data[POS_EMPTY +: SEG_N*EMPTY_W];

    // Output qualifiers aligned with the registered memory data
    always_ff @(posedge clk_i)
    begin
        if (rst_i || flush_q)
        begin
            data_pend_q <= 1'b0;
            line_valid_o <= 1'b0;
            line_error_o <= 1'b0;
            line_fcs_off_o <= 1'b0;
            tx_underrun_flag_o <= 1'b0;
        end
        else
        begin
            data_pend_q <= rd_go;
            line_valid_o <= rd_go || unr_cond;
            line_error_o <= unr_cond || (rd_go && badtag_q[rd_ptr_q]);
            line_fcs_off_o <= rd_go && badtag_q[rd_ptr_q];
            tx_underrun_flag_o <= unr_cond;
        end
    end

    // Packet tracking; a word closing one packet and opening another counts as closed
    always_ff @(posedge clk_i)
    begin
        if (rst_i || flush_q)
        begin
            in_pkt_q <= 1'b0;
        end
        else if (data_pend_q && |rd_last)
        begin
            in_pkt_q <= 1'b0;
        end
        else if (data_pend_q && |rd_first)
        begin
            in_pkt_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Register bus and interrupts
    // ------------------------------------------------------------
    logic req;
    logic wr_req;
    logic [1:0] istat_q;
    logic [1:0] imask_q;
    logic [1:0] ev_set;
    logic [31:0] rd_mux;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_req = req && wb_we_i && wb_sel_i[0];
    assign ev_set = {unr_cond, ovr_ev};
    assign rd_mux = (wb_adr_i == OFF_CTRL) ? {30'h0, ctrl_en_q, 1'b0} :
                    (wb_adr_i == OFF_STAT) ? {26'h0, fill_q, tx_overrun_flag_o} :
                    (wb_adr_i == OFF_ISTAT) ? {30'h0, istat_q} :
                    (wb_adr_i == OFF_IMASK) ? {30'h0, imask_q} : 32'h0;

    // One-cycle ack; unmapped reads return zero, writes drop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_mux : '0;
        end
    end

    // Control writes; flush is a self-clearing pulse
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_en_q <= CTRL_EN_RST;
            flush_q <= 1'b0;
            imask_q <= IMASK_RST;
        end
        else
        begin
            flush_q <= wr_req && (wb_adr_i == OFF_CTRL) && wb_dat_i[CTRL_FLUSH];
            if (wr_req && (wb_adr_i == OFF_CTRL))
            begin
                ctrl_en_q <= wb_dat_i[CTRL_EN];
            end
            if (wr_req && (wb_adr_i == OFF_IMASK))
            begin
                imask_q <= wb_dat_i[1:0];
            end
        end
    end

    // Sticky events, write one to clear; a new event beats the clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            istat_q <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            istat_q <= (istat_q & ~((wr_req && (wb_adr_i == OFF_ISTAT)) ? wb_dat_i[1:0] : 2'h0)) | ev_set;
            irq_o <= |(istat_q & imask_q);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ready_slack_a: assert property (tx_accept_ready_o |-> fill_q < RDY_LIM)
        else $error("ready high with store too full");
    ovr_set_a: assert property (ovr_ev |=> tx_overrun_flag_o)
        else $error("overrun not flagged");
    ovr_hold_a: assert property (tx_overrun_flag_o && !flush_q |=> tx_overrun_flag_o)
        else $error("overrun flag dropped without reset");
    unr_flag_a: assert property (unr_cond |=> tx_underrun_flag_o && line_error_o)
        else $error("underrun not flagged");
    err_block_a: assert property (tx_underrun_flag_o |-> line_valid_o && line_error_o)
        else $error("no error block during underrun");
    seg_capture_a: assert property (wr_go && !rd_go |=> fill_q == $past(fill_q) + 5'h01)
        else $error("enabled segment not stored");
    idle_ignore_a: assert property (!seg_any && !flush_q |=> fill_q <= $past(fill_q))
        else $error("stored with no segment enabled");
    bad_mark_a: assert property (rd_go && badtag_q[rd_ptr_q] |=> line_error_o && line_fcs_off_o)
        else $error("bad packet end not marked");
endmodule

// >>> verif/tb_tsp_tx_ingress.sv
// Self-checking bench for the segmented transmit ingress block
`timescale 1ns/1ps
module tb_tsp_tx_ingress;
    import tsp_pkg::*;
    logic clk_i = 0, rst_i = 1, drain = 0, go = 0, hold = 0, rude = 0, bad = 0, cyc = 0, stb = 0, we = 0, mon = 0;
    logic [7:0] len = 8'h01, pkt = 8'h00, m_pkt = 8'h01, m_beat = 8'h00, adr = 8'h00, want = 8'h00;
    logic [3:0] emp = 4'h0, sel = 4'h0, pv, pf, pl, pb, llv, lf, ll;
    logic [31:0] wdat = 32'h0, rd, wdo;
    logic busy, rdy, ovr, unr, lv, lerr, lfcs, ack, irq;
    logic [LINE_W-1:0] pw, lw;
    logic [15:0] pe, le;
    int errors = 0, checks = 0, seen = 0, unr_seen = 0;
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end
    tsp_src src (.clk_i(clk_i), .rst_i(rst_i), .ready_i(rdy), .go_i(go), .hold_i(hold), .rude_i(rude), .bad_i(bad),
        .len_i(len), .pkt_i(pkt), .empty_i(emp), .busy_o(busy), .word_o(pw), .valid_o(pv), .first_o(pf),
        .last_o(pl), .bad_o(pb), .empty_o(pe));
    tsp_tx_ingress dut (.clk_i(clk_i), .rst_i(rst_i), .tx_seg0_word_i(pw[127:0]), .tx_seg1_word_i(pw[255:128]),
        .tx_seg2_word_i(pw[383:256]), .tx_seg3_word_i(pw[511:384]), .tx_seg0_valid_i(pv[0]), .tx_seg1_valid_i(pv[1]),
        .tx_seg2_valid_i(pv[2]), .tx_seg3_valid_i(pv[3]), .tx_seg0_first_i(pf[0]), .tx_seg1_first_i(pf[1]),
        .tx_seg2_first_i(pf[2]), .tx_seg3_first_i(pf[3]), .tx_seg0_last_i(pl[0]), .tx_seg1_last_i(pl[1]),
        .tx_seg2_last_i(pl[2]), .tx_seg3_last_i(pl[3]), .tx_seg0_bad_packet_i(pb[0]), .tx_seg1_bad_packet_i(pb[1]),
        .tx_seg2_bad_packet_i(pb[2]), .tx_seg3_bad_packet_i(pb[3]), .tx_seg0_empty_count_i(pe[3:0]),
        .tx_seg1_empty_count_i(pe[7:4]), .tx_seg2_empty_count_i(pe[11:8]), .tx_seg3_empty_count_i(pe[15:12]),
        .tx_accept_ready_o(rdy), .tx_overrun_flag_o(ovr), .tx_underrun_flag_o(unr), .drain_ready_i(drain),
        .line_valid_o(lv), .line_word_o(lw), .line_lane_valid_o(llv), .line_first_o(lf), .line_last_o(ll),
        .line_empty_o(le), .line_error_o(lerr), .line_fcs_off_o(lfcs), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(wdo), .wb_ack_o(ack), .irq_o(irq));
    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic check(input logic [LINE_W-1:0] got, input logic [LINE_W-1:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Wait conditions: 0 ready high, 1 ready low, 2 source idle, 3 line monitor caught up
    function automatic bit hit(input int c);
        case (c)
            0: return rdy === 1'b1;
            1: return rdy === 1'b0;
            2: return busy === 1'b0;
            default: return m_pkt === want;
        endcase
    endfunction
    task automatic wait_on(input int c, input int lim);
        int n;
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end
        while (n < lim && !hit(c));
        if (!hit(c))
        begin
            errors++;
            $display("ERROR %0t wait ran out", $time);
            conclude();
        end
    endtask
    // Classic cycle: hold until ack is sampled high at a rising edge, take data there, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (n < 10 && ack !== 1'b1);
        if (ack !== 1'b1)
        begin
            errors++;
            $display("ERROR %0t ack never came", $time);
            conclude();
        end
        rd = wdo;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 32'h0, 4'hF);
        check(rd, exp, what);
    endtask
    task automatic start(input logic [7:0] p, input logic [7:0] l, input logic b, input logic [3:0] e);
        want = p;
        // The monitor reads len, bad and emp live, so they change only once the line shows the last packet
        if (mon)
            wait_on(3, 40);
        @(posedge clk_i);
        pkt <= p;
        len <= l;
        bad <= b;
        emp <= e;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
    endtask
    function automatic logic [LINE_W-1:0] line_exp(input logic [7:0] p, input logic [7:0] b);
        logic [LINE_W-1:0] v;
        for (int g = 0; g < SEG_N; g++)
            v[g*SEG_W +: SEG_W] = {104'h0, p, b, 8'(g)};
        return v;
    endfunction
    // ------------------------------------------------------------
    // Line monitor: each data word against the expected beat
    // ------------------------------------------------------------
    always @(negedge clk_i)
    begin
        if (mon && lv === 1'b1 && unr === 1'b1)
        begin
            unr_seen++;
            check(lerr, 1'b1, "error block");
        end
        else if (mon && lv === 1'b1)
        begin
            check(lw, line_exp(m_pkt, m_beat), "line data");
            check(lf, {3'h0, m_beat == 8'h00}, "first");
            check(ll, {m_beat == len - 8'h01, 3'h0}, "last");
            check(llv, 4'hF, "lanes");
            check(lerr, bad && m_beat == len - 8'h01, "bad word");
            check(lfcs, bad && m_beat == len - 8'h01, "fcs off");
            seen++;
            m_beat++;
            if (m_beat == len)
            begin
                check(le[15:12], bad ? {emp[3], 3'h0} : emp, "empty");
                m_beat = 8'h00;
                m_pkt++;
            end
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        wait_on(0, 5);
        check({ovr, unr, irq}, 3'h0, "reset flags");
        rchk(OFF_CTRL, 32'h2, "ctrl reset");
        wb(1'b1, OFF_IMASK, 32'h3, 4'hE);
        rchk(OFF_IMASK, 32'h0, "sel ignored");
        rchk(8'h10, 32'h0, "unmapped");
        $display("test regs done");
    endtask
    task automatic t_stream();
        drain <= 1'b1;
        mon <= 1'b1;
        start(8'h01, 8'h03, 1'b0, 4'h5);
        wait_on(2, 20);
        start(8'h02, 8'h01, 1'b0, 4'hF);
        wait_on(2, 20);
        start(8'h03, 8'h04, 1'b1, 4'hF);
        wait_on(2, 20);
        repeat (4) @(negedge clk_i);
        check(seen, 8, "stream count");
        repeat (10) @(negedge clk_i);
        check(seen, 8, "idle ignored");
        $display("test stream done");
    endtask
    task automatic t_back();
        @(posedge clk_i);
        drain <= 1'b0;
        start(8'h04, 8'h14, 1'b0, 4'h2);
        wait_on(1, 40);
        repeat (6) @(negedge clk_i);
        check(ovr, 1'b0, "no overrun");
        rchk(OFF_STAT, 32'h18, "fill held");
        drain <= 1'b1;
        wait_on(2, 60);
        repeat (20) @(negedge clk_i);
        check(seen, 28, "resumed count");
        $display("test backpressure done");
    endtask
    task automatic t_unr();
        start(8'h05, 8'h08, 1'b0, 4'h0);
        repeat (3) @(posedge clk_i);
        hold <= 1'b1;
        repeat (4) @(posedge clk_i);
        hold <= 1'b0;
        wait_on(2, 30);
        repeat (4) @(negedge clk_i);
        check(unr_seen > 0, 1'b1, "underrun seen");
        check(seen, 36, "underrun count");
        rchk(OFF_ISTAT, 32'h2, "underrun event");
        $display("test underrun done");
    endtask
    task automatic t_ovr();
        wb(1'b1, OFF_ISTAT, 32'h3, 4'hF);
        drain <= 1'b0;
        mon <= 1'b0;
        rude <= 1'b1;
        start(8'h06, 8'h18, 1'b0, 4'h0);
        wait_on(2, 40);
        rchk(OFF_STAT, 32'h21, "overrun stat");
        rchk(OFF_ISTAT, 32'h1, "overrun event");
        check(irq, 1'b0, "masked irq");
        wb(1'b1, OFF_IMASK, 32'h1, 4'hF);
        @(negedge clk_i);
        check(irq, 1'b1, "irq raised");
        wb(1'b1, OFF_ISTAT, 32'h1, 4'hF);
        @(negedge clk_i);
        check({irq, ovr}, 2'h1, "irq cleared");
        wb(1'b1, OFF_CTRL, 32'h3, 4'hF);
        @(negedge clk_i);
        check(ovr, 1'b0, "flush clears");
        wait_on(0, 5);
        $display("test overrun done");
    endtask
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_stream();
        t_back();
        t_unr();
        t_ovr();
        conclude();
    end
endmodule

// >>> verif/tsp_src.sv
// User packet source model feeding the segmented transmit bus
`timescale 1ns/1ps
module tsp_src
    import tsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ready_i,
    input wire logic go_i,
    input wire logic hold_i,
    input wire logic rude_i,
    input wire logic bad_i,
    input wire logic [7:0] len_i,
    input wire logic [7:0] pkt_i,
    input wire logic [3:0] empty_i,
    output logic busy_o,
    output logic [LINE_W-1:0] word_o,
    output logic [SEG_N-1:0] valid_o,
    output logic [SEG_N-1:0] first_o,
    output logic [SEG_N-1:0] last_o,
    output logic [SEG_N-1:0] bad_o,
    output logic [SEG_N*EMPTY_W-1:0] empty_o
);
    // ------------------------------------------------------------
    // Beat sequencing
    // ------------------------------------------------------------
    logic [7:0] beat_q; // Beat within packet
    logic [7:0] spin_q; // Idle pattern, new every cycle
    logic end_w; // Final beat of packet
    logic send_w; // Beat leaves at this edge
    assign end_w = (beat_q == len_i - 8'h01);
    // Stops the cycle after ready falls and resumes at once; rude mode ignores ready
    assign send_w = busy_o && !hold_i && (ready_i || rude_i);
    // Idle lines move every cycle, so a stale value never passes as data
    always_ff @(posedge clk_i)
    begin
        spin_q <= spin_q + 8'h01;
        valid_o <= 4'h0;
        word_o <= {64{spin_q}};
        first_o <= spin_q[3:0];
        last_o <= ~spin_q[3:0];
        bad_o <= spin_q[7:4];
        empty_o <= {2{spin_q}};
        if (rst_i)
        begin
            spin_q <= 8'h00;
            busy_o <= 1'b0;
            beat_q <= 8'h00;
        end
        else if (go_i && !busy_o)
        begin
            busy_o <= 1'b1;
            beat_q <= 8'h00;
        end
        else if (send_w)
        begin
            valid_o <= 4'hF;
            for (int g = 0; g < SEG_N; g++)
                word_o[g*SEG_W +: SEG_W] <= {104'h0, pkt_i, beat_q, 8'(g)};
            first_o <= {3'h0, beat_q == 8'h00};
            last_o <= {end_w, 3'h0};
            bad_o <= {bad_i && end_w, 3'h0};
            empty_o <= {end_w ? empty_i : 4'h0, 12'h000};
            beat_q <= beat_q + 8'h01;
            busy_o <= !end_w;
        end
    end
endmodule
